// File: flash_pin_regs.svh
`ifndef FLASH_PIN_REGS_SVH
`define FLASH_PIN_REGS_SVH

// ----------------------------------------------------------------------------
// Status register layout
// ----------------------------------------------------------------------------
`define SR_WIDTH 8
`define SR_BIT_STATUS_WRITE_DISABLE 7
`define SR_BIT_QUAD_ENABLE 6
`define SR_BIT_BLOCK_PROTECT_3 5
`define SR_BIT_BLOCK_PROTECT_2 4
`define SR_BIT_BLOCK_PROTECT_1 3
`define SR_BIT_BLOCK_PROTECT_0 2
`define SR_PROTECT_MASK 8'hfc
`define SR_RESET_VALUE 8'h00

// ----------------------------------------------------------------------------
// Link framing
// ----------------------------------------------------------------------------
`define LINK_BYTE_BITS 4'h8
`define LINK_STEP_SINGLE 4'h1
`define LINK_STEP_DUAL 4'h2
`define LINK_STEP_QUAD 4'h4

`endif

// File: flash_pin_pkg.sv
`include "flash_pin_regs.svh"

package flash_pin_pkg;

  typedef enum logic [1:0] {
    LANE_SINGLE = 2'b00,
    LANE_DUAL = 2'b01,
    LANE_QUAD = 2'b10
  } lane_mode_e;

  // Reference clock side
  typedef struct packed {
    logic [`SR_WIDTH-1:0] status;
    logic wr_rejected;
    logic [7:0] tx_data;
    logic tx_tog;
    logic rx_seen;
    logic [7:0] rx_byte;
    logic rx_valid;
    logic rx_first;
    logic armed;
    logic cs_seen;
    logic frame_end;
    logic [1:0] mode;
  } ref_state_s;

  // Link side, cleared at every deselect
  typedef struct packed {
    logic [7:0] in_sh;
    logic [2:0] cnt;
    logic [7:0] out_sh;
    logic out_active;
    logic first;
  } frame_state_s;

  // Link side, kept across frames
  typedef struct packed {
    logic [8:0] slot0;
    logic [8:0] slot1;
    logic rx_tog;
    logic tx_seen;
    logic take_tog;
  } link_state_s;

endpackage

// File: sync2.sv
`timescale 1ns/10ps

module sync2 #(
  parameter int W = 1
) (
  input wire logic clk_i,
  input wire logic clr_i,
  input wire logic [W-1:0] d_i,
  output logic [W-1:0] q_o
);

  logic [W-1:0] meta_r;

  // First stage feeds the second stage only
  always_ff @(posedge clk_i or posedge clr_i) begin
    if (clr_i) begin
      meta_r <= '0;
      q_o <= '0;
    end else begin
      meta_r <= d_i;
      q_o <= meta_r;
    end
  end

endmodule

// File: lane_driver.sv
`timescale 1ns/10ps

module lane_driver #(
  parameter int W = 8
) (
  input wire logic sck_i,
  input wire logic clr_i,
  input wire logic [W-1:0] d_i,
  output logic [W-1:0] q_o
);

  // Launch on the falling edge so the host samples a settled bit on the rise
  always_ff @(negedge sck_i or posedge clr_i) begin
    if (clr_i) begin
      q_o <= '0;
    end else begin
      q_o <= d_i;
    end
  end

endmodule

// File: flash_pin_if.sv
`timescale 1ns/10ps
`include "flash_pin_regs.svh"


module flash_pin_if
  import flash_pin_pkg::*;
#(
  parameter bit DEDICATED_RESET = 1'b0,
  parameter bit RESET_ON_LANE3 = 1'b0
) (
  input wire logic ref_clk_i,
  input wire logic rst_i,
  input wire logic sck_i,
  input wire logic cs_n_i,
  input wire logic data_lane_0_i,
  output logic data_lane_0_o,
  output logic data_lane_0_oe_o,
  input wire logic data_lane_1_i,
  output logic data_lane_1_o,
  output logic data_lane_1_oe_o,
  input wire logic data_lane_2_i,
  output logic data_lane_2_o,
  output logic data_lane_2_oe_o,
  input wire logic data_lane_3_i,
  output logic data_lane_3_o,
  output logic data_lane_3_oe_o,
  input wire logic reset_n_i,
  output logic reset_pullup_o,
  input wire logic [1:0] lane_mode_i,
  input wire logic [7:0] tx_byte_i,
  input wire logic tx_load_i,
  output logic tx_ready_o,
  output logic [7:0] rx_byte_o,
  output logic rx_valid_o,
  output logic rx_first_o,
  output logic frame_end_o,
  input wire logic status_wr_i,
  input wire logic [7:0] status_wdata_i,
  output logic [7:0] status_o,
  output logic status_wr_rejected_o,
  output logic write_protect_o,
  output logic hw_reset_active_o
);

  // --------------------------------------------------------------------------
  // Pin function selection
  // --------------------------------------------------------------------------
  ref_state_s ref_r;
  ref_state_s ref_nxt;
  frame_state_s frame_r;
  frame_state_s frame_nxt;
  link_state_s link_r;
  link_state_s link_nxt;

  logic qe_r;
  logic qe_l;
  logic lane3_reset_r;
  logic lane3_reset_l;
  logic hw_reset_n_raw;
  logic pause_n_raw;
  logic pause_n_l;
  logic link_rst;
  logic frame_clr;
  logic pins_on;

  assign qe_r = ref_r.status[`SR_BIT_QUAD_ENABLE];

  // Shared reset only exists on parts without a dedicated pin, and only while quad is off
  assign lane3_reset_r = !DEDICATED_RESET && RESET_ON_LANE3 && !qe_r;
  assign lane3_reset_l = !DEDICATED_RESET && RESET_ON_LANE3 && !qe_l;

  assign hw_reset_n_raw = DEDICATED_RESET ? reset_n_i : (lane3_reset_r ? data_lane_3_i : 1'b1);
  assign pause_n_raw = (qe_r || lane3_reset_r) ? 1'b1 : data_lane_3_i;
  assign pause_n_l = (qe_l || lane3_reset_l) ? 1'b1 : data_lane_3_i;

  // The weak pull-up sits on the pad; the design only asks for it
  assign reset_pullup_o = DEDICATED_RESET;

  // Async clears take constants only; the link clock may be stopped when they fire
  assign link_rst = rst_i | ~hw_reset_n_raw;
  assign frame_clr = link_rst | cs_n_i;

  // Output enables drop at once; waiting for an edge would leave the lanes driven
  assign pins_on = ~cs_n_i & pause_n_raw & hw_reset_n_raw;

  // --------------------------------------------------------------------------
  // Crossings
  // --------------------------------------------------------------------------
  logic wp_s;
  logic cs_s;
  logic hw_reset_n_s;
  logic rx_tog_s;
  logic take_s;
  logic [3:0] to_link_s;
  logic tx_tog_l;
  logic [1:0] mode_l;

  sync2 #(.W(1)) u_sync_wp (
    .clk_i(ref_clk_i),
    .clr_i(1'b0),
    .d_i(data_lane_2_i),
    .q_o(wp_s)
  );

  sync2 #(.W(1)) u_sync_cs (
    .clk_i(ref_clk_i),
    .clr_i(1'b0),
    .d_i(cs_n_i),
    .q_o(cs_s)
  );

  sync2 #(.W(1)) u_sync_rst (
    .clk_i(ref_clk_i),
    .clr_i(1'b0),
    .d_i(hw_reset_n_raw),
    .q_o(hw_reset_n_s)
  );

  sync2 #(.W(2)) u_sync_to_ref (
    .clk_i(ref_clk_i),
    .clr_i(1'b0),
    .d_i({link_r.rx_tog, link_r.take_tog}),
    .q_o({rx_tog_s, take_s})
  );

  // Mode and quad enable are quasi-static: change them a frame ahead of use
  sync2 #(.W(4)) u_sync_to_link (
    .clk_i(sck_i),
    .clr_i(link_rst),
    .d_i({ref_r.tx_tog, qe_r, ref_r.mode}),
    .q_o(to_link_s)
  );

  assign tx_tog_l = to_link_s[3];
  assign qe_l = to_link_s[2];
  assign mode_l = to_link_s[1:0];

  // --------------------------------------------------------------------------
  // Reference clock side
  // --------------------------------------------------------------------------
  logic int_rst;
  logic protect_on;
  logic [8:0] rx_slot;

  assign int_rst = rst_i | ~hw_reset_n_s;

  // Quad enable hands the pin to lane 2, so the protect level no longer counts
  assign protect_on = ref_r.status[`SR_BIT_STATUS_WRITE_DISABLE] & ~wp_s & ~qe_r;

  // Two slots give the reader two byte times; the sender always fills the other one
  assign rx_slot = rx_tog_s ? link_r.slot0 : link_r.slot1;

  assign tx_ready_o = (ref_r.tx_tog == take_s) & ~int_rst;

  always_comb begin
    ref_nxt = ref_r;
    ref_nxt.rx_valid = 1'b0;
    ref_nxt.frame_end = 1'b0;
    ref_nxt.wr_rejected = 1'b0;
    if (int_rst) begin
      ref_nxt.tx_tog = take_s;
      ref_nxt.rx_seen = rx_tog_s;
      ref_nxt.rx_first = 1'b0;
      ref_nxt.armed = 1'b0;
      ref_nxt.cs_seen = cs_s;
    end else begin
      ref_nxt.mode = lane_mode_i;
      if (status_wr_i) begin
        if (protect_on) begin
          ref_nxt.status = (ref_r.status & `SR_PROTECT_MASK) | (status_wdata_i & ~`SR_PROTECT_MASK);
          ref_nxt.wr_rejected = 1'b1;
        end else begin
          ref_nxt.status = status_wdata_i;
        end
      end
      if (tx_load_i && tx_ready_o) begin
        ref_nxt.tx_data = tx_byte_i;
        ref_nxt.tx_tog = ~ref_r.tx_tog;
      end
      if (rx_tog_s != ref_r.rx_seen) begin
        ref_nxt.rx_seen = rx_tog_s;
        if (ref_r.armed) begin
          ref_nxt.rx_byte = rx_slot[7:0];
          ref_nxt.rx_first = rx_slot[8];
          ref_nxt.rx_valid = 1'b1;
        end
      end
      ref_nxt.cs_seen = cs_s;
      if (cs_s) begin
        ref_nxt.armed = 1'b1;
      end
      if (cs_s && !ref_r.cs_seen && ref_r.armed) begin
        ref_nxt.frame_end = 1'b1;
      end
    end
  end

  always_ff @(posedge ref_clk_i) begin
    if (rst_i) begin
      ref_r <= '0;
      ref_r.status <= `SR_RESET_VALUE;
    end else begin
      ref_r <= ref_nxt;
    end
  end

  assign rx_byte_o = ref_r.rx_byte;
  assign rx_valid_o = ref_r.rx_valid;
  assign rx_first_o = ref_r.rx_first;
  assign frame_end_o = ref_r.frame_end;
  assign status_o = ref_r.status;
  assign status_wr_rejected_o = ref_r.wr_rejected;
  assign write_protect_o = protect_on;
  assign hw_reset_active_o = ~hw_reset_n_s;

  // --------------------------------------------------------------------------
  // Link side: capture on the rising edge
  // --------------------------------------------------------------------------
  logic quad_ok;
  logic [3:0] lanes_in;
  logic [3:0] step;
  logic [3:0] sum;
  logic tx_pending;

  // Quad needs the protect and pause pins as lanes, which quad enable grants
  assign quad_ok = (mode_l == LANE_QUAD) && qe_l;
  assign lanes_in = {data_lane_3_i, data_lane_2_i, data_lane_1_i, data_lane_0_i};
  assign tx_pending = tx_tog_l != link_r.tx_seen;

  always_comb begin
    frame_nxt = frame_r;
    link_nxt = link_r;
    step = `LINK_STEP_SINGLE;
    sum = 4'h0;
    if (pause_n_l) begin
      if (quad_ok) begin
        step = `LINK_STEP_QUAD;
        frame_nxt.in_sh = {frame_r.in_sh[3:0], lanes_in};
        frame_nxt.out_sh = {frame_r.out_sh[3:0], 4'h0};
      end else if (mode_l == LANE_DUAL) begin
        step = `LINK_STEP_DUAL;
        frame_nxt.in_sh = {frame_r.in_sh[5:0], lanes_in[1:0]};
        frame_nxt.out_sh = {frame_r.out_sh[5:0], 2'h0};
      end else begin
        frame_nxt.in_sh = {frame_r.in_sh[6:0], lanes_in[0]};
        frame_nxt.out_sh = {frame_r.out_sh[6:0], 1'h0};
      end
      sum = {1'b0, frame_r.cnt} + step;
      frame_nxt.cnt = sum[2:0];
      if (sum == `LINK_BYTE_BITS) begin
        // Lanes are turned round while reading, so what arrives then is not data
        if (!frame_r.out_active) begin
          if (link_r.rx_tog) begin
            link_nxt.slot1 = {frame_r.first, frame_nxt.in_sh};
          end else begin
            link_nxt.slot0 = {frame_r.first, frame_nxt.in_sh};
          end
          link_nxt.rx_tog = ~link_r.rx_tog;
          frame_nxt.first = 1'b0;
        end
        if (tx_pending) begin
          frame_nxt.out_sh = ref_r.tx_data;
          frame_nxt.out_active = 1'b1;
          link_nxt.tx_seen = tx_tog_l;
          link_nxt.take_tog = ~link_r.take_tog;
        end else begin
          frame_nxt.out_active = 1'b0;
        end
      end
    end
  end

  // A partial byte dies with the frame; pause leaves it untouched
  always_ff @(posedge sck_i or posedge frame_clr) begin
    if (frame_clr) begin
      frame_r <= '0;
      frame_r.first <= 1'b1;
    end else begin
      frame_r <= frame_nxt;
    end
  end

  always_ff @(posedge sck_i or posedge link_rst) begin
    if (link_rst) begin
      link_r <= '0;
    end else begin
      link_r <= link_nxt;
    end
  end

  // --------------------------------------------------------------------------
  // Link side: drive on the falling edge
  // --------------------------------------------------------------------------
  logic [7:0] drive_d;
  logic [7:0] drive_q;

  always_comb begin
    drive_d = 8'h00;
    if (frame_r.out_active) begin
      if (quad_ok) begin
        drive_d = {4'hf, frame_r.out_sh[4], frame_r.out_sh[5], frame_r.out_sh[6], frame_r.out_sh[7]};
      end else if (mode_l == LANE_DUAL) begin
        drive_d = {4'h3, 2'h0, frame_r.out_sh[7], frame_r.out_sh[6]};
      end else begin
        drive_d = {4'h2, 2'h0, frame_r.out_sh[7], 1'b0};
      end
    end
  end

  lane_driver #(.W(8)) u_lane_driver (
    .sck_i(sck_i),
    .clr_i(frame_clr),
    .d_i(drive_d),
    .q_o(drive_q)
  );

  assign data_lane_0_o = drive_q[0];
  assign data_lane_1_o = drive_q[1];
  assign data_lane_2_o = drive_q[2];
  assign data_lane_3_o = drive_q[3];
  assign data_lane_0_oe_o = drive_q[4] & pins_on;
  assign data_lane_1_oe_o = drive_q[5] & pins_on;
  assign data_lane_2_oe_o = drive_q[6] & pins_on;
  assign data_lane_3_oe_o = drive_q[7] & pins_on;

endmodule

// File: flash_pin_checker.sv
`timescale 1ns/10ps

// ----
// Pin behaviour checks
// ----
module flash_pin_checker (
  input wire logic ref_clk_i,
  input wire logic rst_i,
  input wire logic cs_n_i,
  input wire logic data_lane_0_oe_o,
  input wire logic data_lane_1_oe_o,
  input wire logic data_lane_2_oe_o,
  input wire logic data_lane_3_oe_o,
  input wire logic data_lane_3_i,
  input wire logic [1:0] lane_mode_i,
  input wire logic status_wr_i,
  input wire logic [7:0] status_wdata_i,
  input wire logic [7:0] status_o,
  input wire logic status_wr_rejected_o,
  input wire logic write_protect_o,
  input wire logic hw_reset_active_o,
  input wire logic frame_end_o
);
  default clocking cb @(posedge ref_clk_i);
  endclocking
  default disable iff (rst_i);

  a_cs_quiet: assert property (cs_n_i |-> !(data_lane_0_oe_o || data_lane_1_oe_o || data_lane_2_oe_o))
    else $error("lane driven while deselected");
  a_pause_hiz: assert property ((!cs_n_i && !data_lane_3_i && !status_o[6]) |-> !data_lane_1_oe_o)
    else $error("output lane driven during pause");
  a_protect_when: assert property (write_protect_o |-> (status_o[7] && !status_o[6]))
    else $error("protection without write disable or with quad enable");
  a_reject_keeps: assert property ((status_wr_i && write_protect_o && !hw_reset_active_o) |=>
    (status_o[7:2] == $past(status_o[7:2]) && status_o[1:0] == $past(status_wdata_i[1:0]) && status_wr_rejected_o))
    else $error("protected status bits changed");
  a_write_takes: assert property ((status_wr_i && !write_protect_o && !hw_reset_active_o) |=>
    status_o == $past(status_wdata_i))
    else $error("status write not taken");
  a_reject_cause: assert property (status_wr_rejected_o |-> $past(status_wr_i && write_protect_o))
    else $error("reject pulse without a blocked write");
  a_single_lanes: assert property ((lane_mode_i == 2'h0) |-> !(data_lane_0_oe_o || data_lane_2_oe_o))
    else $error("input lane driven in single mode");
  a_end_deselect: assert property (frame_end_o |-> (cs_n_i && $past(cs_n_i)))
    else $error("frame end while selected");
endmodule

bind flash_pin_if flash_pin_checker chk (.ref_clk_i, .rst_i, .cs_n_i, .data_lane_0_oe_o, .data_lane_1_oe_o,
  .data_lane_2_oe_o, .data_lane_3_oe_o, .data_lane_3_i, .lane_mode_i, .status_wr_i, .status_wdata_i, .status_o,
  .status_wr_rejected_o, .write_protect_o, .hw_reset_active_o, .frame_end_o);

// File: spi_host_model.sv
`timescale 1ns/10ps

// ----
// Host controller, mode 0
// ----
module spi_host_model (
  output logic sck_o,
  output logic cs_n_o,
  output logic mosi_o,
  output logic pause_n_o,
  input wire logic miso_i
);
  // Never drives the reset pin, so no reset lands mid write
  initial begin
    sck_o = 1'b0;
    cs_n_o = 1'b1;
    mosi_o = 1'b0;
    pause_n_o = 1'b1;
  end

  task automatic select(input logic on);
    #5 cs_n_o = !on;
    // Released line shows the inverse so a stale level cannot pass
    if (!on) mosi_o = !mosi_o;
    #5;
  endtask

  task automatic idle_pause();
    #5 pause_n_o = 1'b0;
    #20 pause_n_o = 1'b1;
  endtask

  // Clock only runs inside frames; pause_at of 8 or more means no pause
  task automatic xfer(input logic [7:0] d, input int nbits, input int pause_at, output logic [7:0] q);
    q = 8'h00;
    for (int i = 7; i > 7 - nbits; i--) begin
      if (7 - i == pause_at) begin
        pause_n_o = 1'b0;
        repeat (3) begin
          mosi_o = !mosi_o;
          #7.5 sck_o = 1'b1;
          #7.5 sck_o = 1'b0;
        end
        pause_n_o = 1'b1;
      end
      mosi_o = d[i];
      #7.5 sck_o = 1'b1;
      q[i] = miso_i;
      #7.5 sck_o = 1'b0;
    end
  endtask
endmodule

// File: tb.sv
`timescale 1ns/10ps

// ----
// Testbench
// ----
module tb;
  logic ref_clk_i, rst_i, tx_load_i, status_wr_i, wp_level, tog, pu;
  logic [1:0] lane_mode;
  logic [7:0] tx_byte_i, status_wdata_i, q, rx_byte_o, status_o;
  logic o0, e0, o1, e1, o2, e2, o3, e3, tx_ready_o, rx_valid_o, rx_first_o, frame_end_o, rej, wpo, hwr;
  wire sck, cs_n, mosi, pause_n;
  // Undriven output lane toggles every cycle instead of holding a value
  wire lane1 = e1 ? o1 : tog;
  wire lane0 = e0 ? o0 : mosi;
  wire lane2 = e2 ? o2 : wp_level;
  wire lane3 = e3 ? o3 : pause_n;
  int n_mismatch, n_tests, n_rej, n_end;
  logic [8:0] rxq[$];
  logic [16:0] tbl[6] = '{{1'b1, 8'h8f, 8'h8f}, {1'b0, 8'h00, 8'h8c}, {1'b1, 8'h10, 8'h10},
    {1'b0, 8'h24, 8'h24}, {1'b0, 8'hc0, 8'hc0}, {1'b0, 8'h00, 8'h00}};

  spi_host_model host (.sck_o(sck), .cs_n_o(cs_n), .mosi_o(mosi), .pause_n_o(pause_n), .miso_i(lane1));

  flash_pin_if uut (.ref_clk_i(ref_clk_i), .rst_i(rst_i), .sck_i(sck), .cs_n_i(cs_n),
    .data_lane_0_i(lane0), .data_lane_0_o(o0), .data_lane_0_oe_o(e0),
    .data_lane_1_i(lane1), .data_lane_1_o(o1), .data_lane_1_oe_o(e1),
    .data_lane_2_i(lane2), .data_lane_2_o(o2), .data_lane_2_oe_o(e2),
    .data_lane_3_i(lane3), .data_lane_3_o(o3), .data_lane_3_oe_o(e3),
    .reset_n_i(1'b1), .reset_pullup_o(pu), .lane_mode_i(lane_mode), .tx_byte_i(tx_byte_i), .tx_load_i(tx_load_i),
    .tx_ready_o(tx_ready_o), .rx_byte_o(rx_byte_o), .rx_valid_o(rx_valid_o), .rx_first_o(rx_first_o),
    .frame_end_o(frame_end_o), .status_wr_i(status_wr_i), .status_wdata_i(status_wdata_i),
    .status_o(status_o), .status_wr_rejected_o(rej), .write_protect_o(wpo), .hw_reset_active_o(hwr));

  initial begin
    ref_clk_i = 1'b0;
    forever #10 ref_clk_i = !ref_clk_i;
  end

  always @(posedge ref_clk_i) begin
    tog <= !tog;
    if (rx_valid_o === 1'b1) rxq.push_back({rx_first_o, rx_byte_o});
    if (rej === 1'b1) n_rej++;
    if (frame_end_o === 1'b1) n_end++;
  end

  task automatic check(input logic [8:0] seen, input logic [8:0] exp);
    n_tests++;
    if (seen !== exp) begin
      n_mismatch++;
      $display("CHECK FAILED at %0t: seen %h expected %h", $time, seen, exp);
    end
  endtask

  task automatic tick(input int n);
    repeat (n) @(posedge ref_clk_i);
    #1;
  endtask

  task automatic wr_status(input logic wp, input logic [7:0] d);
    wp_level = wp;
    tick(4);
    status_wdata_i = d;
    status_wr_i = 1'b1;
    tick(1);
    status_wr_i = 1'b0;
  endtask

  task automatic load_tx(input logic [7:0] d);
    int k;
    k = 0;
    while (tx_ready_o !== 1'b1 && k < 50) begin
      tick(1);
      k++;
    end
    tx_byte_i = d;
    tx_load_i = 1'b1;
    tick(1);
    tx_load_i = 1'b0;
    check(tx_ready_o, 9'h000);
  endtask

  task automatic frame(input logic [7:0] d0, input logic [7:0] d1, input int nb, input int pz);
    host.select(1'b1);
    host.xfer(d0, 8, pz, q);
    host.xfer(d1, nb, pz, q);
    host.select(1'b0);
    tick(8);
  endtask

  task automatic expect_rx(input int n, input logic [8:0] a, input logic [8:0] b);
    check(9'(rxq.size()), 9'(n));
    if (n > 0) check(rxq.pop_front(), a);
    if (n > 1) check(rxq.pop_front(), b);
    rxq.delete();
  endtask

  task automatic end_sim();
    $display("mismatches %0d, comparisons %0d", n_mismatch, n_tests);
    if (n_mismatch == 0 && n_tests > 0) begin
      $display("verification passed");
    end else begin
      $display("verification failed");
    end
    $finish;
  endtask

  initial begin
    #60000;
    n_mismatch++;
    end_sim();
  end

  initial begin
    rst_i = 1'b1;
    tx_load_i = 1'b0;
    status_wr_i = 1'b0;
    tx_byte_i = 8'h00;
    status_wdata_i = 8'h00;
    wp_level = 1'b1;
    lane_mode = 2'h0;
    tog = 1'b0;
    n_mismatch = 0;
    n_tests = 0;
    n_rej = 0;
    n_end = 0;
    tick(12);
    check(status_o, 9'h000);
    check(tx_ready_o, 9'h000);
    rst_i = 1'b0;
    tick(6);
    check(hwr, 9'h000);
    check(pu, 9'h000);
    host.idle_pause();
    frame(8'ha5, 8'h3c, 8, 8);
    expect_rx(2, {1'b1, 8'ha5}, {1'b0, 8'h3c});
    frame(8'h5a, 8'hc3, 8, 3);
    expect_rx(2, {1'b1, 8'h5a}, {1'b0, 8'hc3});
    frame(8'he7, 8'h81, 5, 8);
    expect_rx(1, {1'b1, 8'he7}, 9'h000);
    // Quad asked for without quad enable falls back to the single lane
    lane_mode = 2'h2;
    tick(2);
    frame(8'h96, 8'h69, 8, 8);
    expect_rx(2, {1'b1, 8'h96}, {1'b0, 8'h69});
    lane_mode = 2'h0;
    tick(2);
    load_tx(8'hc6);
    frame(8'h0b, 8'h00, 8, 4);
    check(q, 9'h0c6);
    check(tx_ready_o, 9'h001);
    expect_rx(1, {1'b1, 8'h0b}, 9'h000);
    for (int i = 0; i < 6; i++) begin
      wr_status(tbl[i][16], tbl[i][15:8]);
      check(status_o, tbl[i][7:0]);
    end
    check(9'(n_rej), 9'h001);
    check(9'(n_end), 9'h005);
    end_sim();
  end
endmodule
